// ### verilog/srl_ctrl.sv
// Transceiver reset chain, loopback select and transmit data path control
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "srl_cfg.svh"
module srl_ctrl (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic testmode,
    input wire logic loop_rst_in,
    input wire logic xmit_rst_in,
    input wire logic xmit_coding_rst_in,
    input wire logic xmit_attach_rst_in,
    input wire logic recv_rst_in,
    input wire logic recv_coding_rst_in,
    input wire logic recv_recovery_rst_in,
    input wire logic recv_equalizer_rst_in,
    input wire logic [2:0] loop_select_in,
    input wire logic encoder_en_in,
    input wire logic [63:0] xmit_data_in,
    input wire logic [7:0] xmit_disparity_mode_in,
    input wire logic [7:0] xmit_disparity_value_in,
    input wire logic xmit_valid_in,
    output logic loop_locked,
    output srl_pkg::srl_rst_t xmit_rst_out,
    output srl_pkg::srl_rst_t recv_rst_out,
    output logic xmit_rst_done,
    output logic recv_rst_done,
    output srl_pkg::srl_loop_t loop_out,
    output logic [79:0] xmit_word_out,
    output logic xmit_word_valid_out
);
    // Register fields
    logic [1:0] width_q;
    logic loop_en_q;
    logic xlo_q;
    logic [1:0] xattach_q;
    logic xcoding_q;
    logic rlo_q;
    logic rattach_q;
    logic rcoding_q;
    logic dovr_q;
    logic [2:0] ptr_q;
    logic dvalid_q;
    logic cro_q;
    logic crv_q;
    logic [4:0] crcyc_q;
    logic pro_q;
    logic prv_q;
    // Override word, 16-bit lanes of 80 bits
    logic [15:0] win_q [0:4];
    logic [2:0] ptr_d;
    logic ack_q;

    // Bus decode
    wire req = cyc_i & stb_i & ~ack_q;
    // Access acts at the edge where ack is high, so reads see pre-step state
    wire take = cyc_i & stb_i & ack_q;
    wire wr = take & we_i & sel_i[0];
    wire hit_width = adr_i == `SRL_OFS_WIDTH;
    wire hit_loop = adr_i == `SRL_OFS_LOOP_EN;
    wire hit_lb = adr_i == `SRL_OFS_LOOPBACK;
    wire hit_dctl = adr_i == `SRL_OFS_DATA_CTL;
    wire hit_win = adr_i == `SRL_OFS_DATA_WIN;
    wire hit_rctl = adr_i == `SRL_OFS_RST_CTL;
    wire hit_stat = adr_i == `SRL_OFS_STATUS;
    // Either direction of window access steps the pointer
    wire win_acc = take & hit_win;
    // Last lane index for the chosen width
    wire [2:0] ptr_last = width_q[1] ? 3'h4 : (width_q[0] ? 3'h1 : 3'h0);

    // Pointer step with wrap at the width's word count
    always_comb begin
        ptr_d = ptr_q;
        if (wr && hit_dctl) begin
            ptr_d = dat_i[3:1];
        end else if (win_acc) begin
            ptr_d = (ptr_q >= ptr_last) ? 3'h0 : ptr_q + 3'h1;
        end
    end

    // Single-cycle answer, ack dropped the cycle after
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end
    assign ack_o = ack_q;

    // Software writes to control fields
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            width_q <= `SRL_WIDTH_RST;
            loop_en_q <= 1'b0;
            {xlo_q, xattach_q, xcoding_q} <= 4'h0;
            {rlo_q, rattach_q, rcoding_q} <= 3'h0;
            {dovr_q, dvalid_q} <= 2'h0;
            ptr_q <= 3'h0;
            {cro_q, crv_q, pro_q, prv_q} <= 4'h0;
            crcyc_q <= `SRL_CRST_CYC_RST;
        end else begin
            ptr_q <= ptr_d;
            if (wr && hit_width) begin
                width_q <= dat_i[`SRL_WIDTH_LSB+1:`SRL_WIDTH_LSB];
            end
            if (wr && hit_loop) begin
                loop_en_q <= dat_i[0];
            end
            if (wr && hit_lb) begin
                xlo_q <= dat_i[0];
                xattach_q <= {1'b0, dat_i[1]};
                xcoding_q <= dat_i[3];
                rlo_q <= dat_i[4];
                rattach_q <= dat_i[5];
                rcoding_q <= dat_i[6];
            end
            if (wr && hit_dctl) begin
                dovr_q <= dat_i[0];
                dvalid_q <= dat_i[4];
            end
            if (wr && hit_rctl) begin
                cro_q <= dat_i[0];
                crv_q <= dat_i[1];
                crcyc_q <= dat_i[6:2];
                pro_q <= dat_i[7];
                prv_q <= dat_i[8];
            end
        end
    end

    // Window lanes, one per 16-bit word
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_lane
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    win_q[gi] <= 16'h0000;
                end else if (wr && hit_win && ptr_q == 3'(gi)) begin
                    win_q[gi] <= dat_i[15:0];
                end
            end
        end
    endgenerate

    // Lock model: loop locks a fixed time after enable
    logic [5:0] lock_cnt_q;
    wire loop_hold = loop_rst_in | ~loop_en_q;
    always_ff @(posedge mclk or posedge loop_hold) begin
        if (loop_hold) begin
            lock_cnt_q <= 6'h00;
        end else if (lock_cnt_q != `SRL_LOCK_CYC) begin
            lock_cnt_q <= lock_cnt_q + 6'h01;
        end
    end
    assign loop_locked = lock_cnt_q == `SRL_LOCK_CYC;

    // Combined asynchronous path resets
    wire tm_path = testmode & pro_q;
    wire x_hold = ~loop_locked | (tm_path ? prv_q : xmit_rst_in);
    wire r_hold = ~loop_locked | recv_rst_in;

    // Transmit completion after coding reset pulse
    logic [4:0] crc_q;
    logic xdone_q;
    always_ff @(posedge mclk or posedge x_hold) begin
        if (x_hold) begin
            crc_q <= 5'h00;
            xdone_q <= 1'b0;
        end else if (crc_q < crcyc_q) begin
            crc_q <= crc_q + 5'h01;
        end else begin
            xdone_q <= 1'b1;
        end
    end
    wire crst_int = ~xdone_q & (crc_q < crcyc_q);

    // Receive completes a fixed lag after transmit
    logic [3:0] rlag_q;
    logic rdone_q;
    always_ff @(posedge mclk or posedge r_hold) begin
        if (r_hold) begin
            rlag_q <= 4'h0;
            rdone_q <= 1'b0;
        end else if (!xdone_q) begin
            rlag_q <= 4'h0;
        end else if (rlag_q != `SRL_RX_LAG_CYC) begin
            rlag_q <= rlag_q + 4'h1;
        end else begin
            rdone_q <= 1'b1;
        end
    end
    assign xmit_rst_done = xdone_q;
    assign recv_rst_done = rdone_q;

    // Sublayer resets include their path reset, except transmit elastic (tied low) and transmit coding under override
    wire tm_cr = testmode & cro_q;
    assign xmit_rst_out.path = x_hold;
    assign xmit_rst_out.coding = tm_cr ? crv_q
        : (x_hold | crst_int | xmit_coding_rst_in);
    assign xmit_rst_out.attach = x_hold | xmit_attach_rst_in;
    assign xmit_rst_out.recovery = x_hold;
    assign xmit_rst_out.equalizer = x_hold;
    assign xmit_rst_out.elastic = 1'b0;
    assign recv_rst_out.path = r_hold;
    assign recv_rst_out.coding = r_hold | recv_coding_rst_in;
    assign recv_rst_out.attach = r_hold;
    assign recv_rst_out.recovery = r_hold | recv_recovery_rst_in;
    assign recv_rst_out.equalizer = r_hold | recv_equalizer_rst_in;
    assign recv_rst_out.elastic = r_hold;

    // Loopback selection
    wire tx_ovr = testmode & xlo_q;
    wire rx_ovr = testmode & rlo_q;
    wire [2:0] ls = loop_select_in;
    assign loop_out.near_coding = tx_ovr ? xcoding_q
        : (ls == srl_pkg::SRL_LB_NEAR_CODING);
    assign loop_out.near_attach = tx_ovr ? (xattach_q == 2'h1)
        : (ls == srl_pkg::SRL_LB_NEAR_ATTACH | xattach_q == 2'h1);
    assign loop_out.far_attach = rx_ovr ? rattach_q
        : (ls == srl_pkg::SRL_LB_FAR_ATTACH);
    assign loop_out.far_coding = rx_ovr ? rcoding_q
        : (ls == srl_pkg::SRL_LB_FAR_CODING);

    // Fabric word, interleaving disparity bits when encoder is off
    logic [79:0] fab_word;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_byte
            assign fab_word[gi*10 +: 10] = encoder_en_in
                ? {2'b00, xmit_data_in[gi*8 +: 8]}
                : {xmit_disparity_mode_in[gi], xmit_disparity_value_in[gi],
                   xmit_data_in[gi*8 +: 8]};
        end
    endgenerate
    wire [79:0] reg_word = {win_q[4], win_q[3], win_q[2], win_q[1], win_q[0]};
    wire [79:0] w_mask = width_q[1] ? {80{1'b1}}
        : (width_q[0] ? {40'h0, {40{1'b1}}} : {60'h0, {20{1'b1}}});
    wire dsel = testmode & dovr_q;

    // Registered transmit word
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            xmit_word_out <= 80'h0;
            xmit_word_valid_out <= 1'b0;
        end else begin
            xmit_word_out <= (dsel ? reg_word : fab_word) & w_mask;
            xmit_word_valid_out <= dsel ? dvalid_q : xmit_valid_in;
        end
    end

    // Read mux
    wire [15:0] win_rd = (ptr_q < 3'h5) ? win_q[ptr_q] : 16'h0000;
    always_comb begin
        dat_o = 32'h0;
        if (hit_width) dat_o[`SRL_WIDTH_LSB+1:`SRL_WIDTH_LSB] = width_q;
        if (hit_loop) dat_o[0] = loop_en_q;
        if (hit_lb) dat_o[6:0] = {rcoding_q, rattach_q, rlo_q, xcoding_q,
                                  xattach_q, xlo_q};
        if (hit_dctl) dat_o[4:0] = {dvalid_q, ptr_q, dovr_q};
        if (hit_win) dat_o[15:0] = win_rd;
        if (hit_rctl) dat_o[8:0] = {prv_q, pro_q, crcyc_q, crv_q, cro_q};
        if (hit_stat) dat_o[2:0] = {loop_locked, rdone_q, xdone_q};
    end

    // Checks
    // Receive completion never comes ahead of transmit completion
    chk_done_order: assert property (
        @(posedge mclk) disable iff (rst)
        $rose(rdone_q) |-> xdone_q)
        else $error("receive done before transmit done");
    // No path reports completion while the loop is unlocked
    chk_hold_lock: assert property (
        @(posedge mclk) disable iff (rst)
        !loop_locked |-> !xmit_rst_done && !recv_rst_done)
        else $error("path done without lock");
    // Loop reset holds both path resets
    chk_loop_rst: assert property (
        @(posedge mclk) disable iff (rst)
        loop_rst_in |-> xmit_rst_out.path && recv_rst_out.path)
        else $error("loop reset not forcing paths");
    // Elastic buffer follows the receive path reset
    chk_elastic_rst: assert property (
        @(posedge mclk) disable iff (rst)
        recv_rst_out.elastic == recv_rst_out.path)
        else $error("elastic buffer reset mismatch");
    // Pointer returns to lane 0 after the last lane of the width
    chk_ptr_wrap: assert property (
        @(posedge mclk) disable iff (rst)
        win_acc && ptr_q >= ptr_last |=> ptr_q == 3'h0)
        else $error("pointer did not wrap");
    // Pointer steps by one below the last lane
    chk_ptr_step: assert property (
        @(posedge mclk) disable iff (rst)
        win_acc && ptr_q < ptr_last |=> ptr_q == $past(ptr_q) + 3'h1)
        else $error("pointer did not step");
    // Internal coding reset lasts the default three cycles
    chk_coding_pulse: assert property (
        @(posedge mclk) disable iff (rst)
        $fell(x_hold) && crcyc_q == `SRL_CRST_CYC_RST && !tm_cr
        && !xmit_coding_rst_in |-> xmit_rst_out.coding [*3] ##1 !xmit_rst_out.coding)
        else $error("coding reset length wrong");
    // Transmit completion stays up until its path is reset again
    chk_done_stays: assert property (
        @(posedge mclk) disable iff (rst)
        $past(xdone_q) && !x_hold |-> xdone_q)
        else $error("transmit done dropped");
    // Fabric code 110 selects far-end coding loopback
    chk_far_code: assert property (
        @(posedge mclk) disable iff (rst)
        !rx_ovr && ls == 3'h6 |-> loop_out.far_coding)
        else $error("far coding loop not selected");
    // Receive completion waits out the lag after transmit completion
    chk_recv_lag: assert property (
        @(posedge mclk) disable iff (rst)
        $rose(rdone_q) |-> $past(xdone_q, 8))
        else $error("receive done too soon");
    // Unlocked loop holds both paths in reset
    chk_lock_paths: assert property (
        @(posedge mclk) disable iff (rst)
        !loop_locked |-> xmit_rst_out.path && recv_rst_out.path)
        else $error("path left reset without lock");
    // Transmit path reset reaches its coding and attach sublayers
    chk_xmit_subs: assert property (
        @(posedge mclk) disable iff (rst)
        x_hold && !tm_cr |-> xmit_rst_out.coding && xmit_rst_out.attach)
        else $error("transmit sublayer not in reset");
    // Receive path reset reaches its coding, recovery, equalizer and attach sublayers
    chk_recv_subs: assert property (
        @(posedge mclk) disable iff (rst)
        r_hold |-> recv_rst_out.coding && recv_rst_out.recovery
            && recv_rst_out.equalizer && recv_rst_out.attach)
        else $error("receive sublayer not in reset");
    // Register value drives the coding reset under override
    chk_coding_ovr: assert property (
        @(posedge mclk) disable iff (rst)
        tm_cr |-> xmit_rst_out.coding == crv_q)
        else $error("coding reset override ignored");
    // Path reset override value forces the transmit path reset
    chk_path_ovr: assert property (
        @(posedge mclk) disable iff (rst)
        tm_path && prv_q |-> xmit_rst_out.path && !xmit_rst_done)
        else $error("path reset override ignored");
    // Coding loop bit under override forces near coding loopback
    chk_near_ovr: assert property (
        @(posedge mclk) disable iff (rst)
        tx_ovr && xcoding_q |-> loop_out.near_coding)
        else $error("near coding override ignored");
    // Register valid bit follows through while data is overridden
    chk_word_valid: assert property (
        @(posedge mclk) disable iff (rst)
        dsel |=> xmit_word_valid_out == $past(dvalid_q))
        else $error("override valid not passed");
    // Main scenarios reached
    cov_both_done: cover property (@(posedge mclk) $rose(rdone_q));
    cov_override: cover property (@(posedge mclk) dsel && xmit_word_valid_out);
    cov_wrap: cover property (@(posedge mclk) win_acc && ptr_q == 3'h4);
    cov_near_ovr: cover property (@(posedge mclk)
        tx_ovr && loop_out.near_coding);
    cov_path_ovr: cover property (@(posedge mclk) tm_path && prv_q);
endmodule : srl_ctrl

// ### verilog/srl_cfg.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SRL_CFG_SVH
`define SRL_CFG_SVH
`define SRL_OFS_WIDTH 8'h40
`define SRL_OFS_LOOP_EN 8'h50
`define SRL_OFS_LOOPBACK 8'h60
`define SRL_OFS_DATA_CTL 8'h64
`define SRL_OFS_DATA_WIN 8'h68
`define SRL_OFS_RST_CTL 8'h6C
`define SRL_OFS_STATUS 8'h70
`define SRL_WIDTH_LSB 3
`define SRL_WIDTH_RST 2'h3
`define SRL_CRST_CYC_RST 5'h03
`define SRL_RX_LAG_CYC 4'h8
`define SRL_LOCK_CYC 6'h20
`endif

// ### verilog/srl_pkg.sv
// Types shared by the transceiver control block
package srl_pkg;
    // Loopback code on the fabric select input
    typedef enum logic [2:0] {
        SRL_LB_NORMAL = 3'h0,
        SRL_LB_NEAR_CODING = 3'h1,
        SRL_LB_NEAR_ATTACH = 3'h2,
        SRL_LB_FAR_ATTACH = 3'h4,
        SRL_LB_FAR_CODING = 3'h6
    } srl_lb_t;
    // Resets driven into one data path
    typedef struct packed {
        logic path;
        logic coding;
        logic attach;
        logic recovery;
        logic equalizer;
        logic elastic;
    } srl_rst_t;
    // Loopback enables decoded for the analog side
    typedef struct packed {
        logic near_coding;
        logic near_attach;
        logic far_attach;
        logic far_coding;
    } srl_loop_t;
endpackage : srl_pkg

// ### verification/srl_fabric_model.sv
// Fabric-side model driving loopback code and transmit words
`timescale 1ns/10ps
module srl_fabric_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] code_req,
    input wire logic run,
    input wire logic xmit_rst_done,
    output logic [2:0] loop_select_in,
    output logic [63:0] xmit_data_in,
    output logic [7:0] xmit_disparity_mode_in,
    output logic [7:0] xmit_disparity_value_in,
    output logic xmit_valid_in
);
    // Two-flop synchroniser on the reset-complete flag
    logic [1:0] done_q;
    // Word counter, advances only while run is high
    logic [7:0] cnt_q;
    // Reserved codes are never driven, normal mode goes out instead
    assign loop_select_in = (code_req[0] && code_req[2:1] != 2'h0) ?
        3'h0 : code_req;
    // Byte pattern changes with every step of the counter
    assign xmit_data_in = {8{cnt_q}} ^ 64'h0706050403020100;
    assign xmit_disparity_mode_in = cnt_q ^ 8'h5A;
    assign xmit_disparity_value_in = ~cnt_q;
    // Words are only marked valid once the flag is synchronised
    assign xmit_valid_in = done_q[1];
    // Runs on mclk, the same bench clock as the control block
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            done_q <= 2'h0;
            cnt_q <= 8'h00;
        end else begin
            done_q <= {done_q[0], xmit_rst_done};
            cnt_q <= cnt_q + {7'h00, run};
        end
    end
endmodule : srl_fabric_model

// ### verification/tb_top.sv
// Self-checking bench for the transceiver control block
`timescale 1ns/10ps
module tb_top;
    logic mclk, rst, cyc_i, stb_i, we_i, testmode, encoder_en_in, run;
    logic [7:0] adr_i;
    logic [31:0] dat_i, dat_o, q;
    logic [3:0] sel_i;
    logic ack_o, loop_locked, xmit_rst_done, recv_rst_done;
    logic loop_rst_in, xmit_rst_in, xmit_coding_rst_in, xmit_attach_rst_in;
    logic recv_rst_in, recv_coding_rst_in, recv_recovery_rst_in;
    logic recv_equalizer_rst_in, xmit_valid_in, xmit_word_valid_out;
    logic [2:0] code_req, loop_select_in;
    logic [63:0] xmit_data_in;
    logic [7:0] xmit_disparity_mode_in, xmit_disparity_value_in;
    logic [79:0] xmit_word_out;
    srl_pkg::srl_rst_t xmit_rst_out, recv_rst_out;
    srl_pkg::srl_loop_t loop_out;
    int error_cnt = 0, checks_done = 0, n, crst_n;
    // Code tables for fabric select and register override
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h3};
    logic [3:0] lexp [6] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'h0};
    logic [31:0] ovr [4] = '{32'h09, 32'h03, 32'h30, 32'h50};
    logic [3:0] oexp [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    srl_ctrl dut (.mclk, .rst, .adr_i, .dat_i, .dat_o, .sel_i, .we_i,
        .cyc_i, .stb_i, .ack_o, .testmode, .loop_rst_in, .xmit_rst_in,
        .xmit_coding_rst_in, .xmit_attach_rst_in, .recv_rst_in,
        .recv_coding_rst_in, .recv_recovery_rst_in, .recv_equalizer_rst_in,
        .loop_select_in, .encoder_en_in, .xmit_data_in,
        .xmit_disparity_mode_in, .xmit_disparity_value_in, .xmit_valid_in,
        .loop_locked, .xmit_rst_out, .recv_rst_out, .xmit_rst_done,
        .recv_rst_done, .loop_out, .xmit_word_out, .xmit_word_valid_out);
    srl_fabric_model fab (.mclk, .rst, .code_req, .run, .xmit_rst_done,
        .loop_select_in, .xmit_data_in, .xmit_disparity_mode_in,
        .xmit_disparity_value_in, .xmit_valid_in);
    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Counts coding reset cycles between lock and completion
    always @(posedge mclk) begin
        if (loop_locked && xmit_rst_out.coding && !xmit_rst_done) crst_n++;
    end
    // Watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end
    task automatic check(input string what, input logic [79:0] seen,
        input logic [79:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One classic Wishbone cycle, the watchdog bounds the wait for ack
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'hF};
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge mclk);
        end while (ack_o !== 1'b1);
        check("ack", ack_o, 1'b1);
        q = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), q, e);
    endtask : rdc
    // Waits for both completions; receive done is low first unless only
    // the transmit path was reset
    task automatic wait_both(input logic rx_exp);
        n = 0;
        while (xmit_rst_done !== 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        check("recv early", recv_rst_done, rx_exp);
        while (recv_rst_done !== 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        check("xmit done held", xmit_rst_done, 1'b1);
        check("recv done", recv_rst_done, 1'b1);
    endtask : wait_both
    function automatic logic [79:0] ext(input logic [63:0] d,
        input logic [7:0] m, input logic [7:0] v);
        logic [79:0] r;
        for (int i = 0; i < 8; i++) r[10*i +: 10] = {m[i], v[i], d[8*i +: 8]};
        return r;
    endfunction : ext
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        {cyc_i, stb_i, we_i, testmode, encoder_en_in, run} = 6'h00;
        {adr_i, dat_i, sel_i, code_req} = '0;
        {loop_rst_in, xmit_rst_in, xmit_coding_rst_in} = 3'h0;
        {xmit_attach_rst_in, recv_rst_in, recv_coding_rst_in} = 3'h0;
        {recv_recovery_rst_in, recv_equalizer_rst_in} = 2'h0;
        rst = 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rdc(8'h40, 32'h18);
        rdc(8'h60, 32'h00);
        rdc(8'h64, 32'h00);
        rdc(8'h6C, 32'h0C);
        rdc(8'h70, 32'h00);
        rdc(8'h7C, 32'h00);
        check("xmit held", xmit_rst_out.path, 1'b1);
        check("recv held", recv_rst_out.path, 1'b1);
        $display("test defaults done");
        wr(8'h6C, 32'h14);
        run <= 1'b1;
        wr(8'h50, 32'h01);
        repeat (5) @(posedge mclk);
        check("early lock", loop_locked, 1'b0);
        check("xmit pre lock", xmit_rst_out.path, 1'b1);
        wait_both(1'b0);
        check("coding cycles", crst_n, 80'd5);
        rdc(8'h70, 32'h07);
        $display("test chain done");
        @(posedge mclk);
        loop_rst_in <= 1'b1;
        #2 check("loop rst", {xmit_rst_out.path, recv_rst_out.path}, 2'h3);
        repeat (2) @(posedge mclk);
        check("done drop", {xmit_rst_done, recv_rst_done}, 2'h0);
        loop_rst_in <= 1'b0;
        wait_both(1'b0);
        @(posedge mclk);
        xmit_rst_in <= 1'b1;
        #2 check("xmit subs", xmit_rst_out[5:3], 3'h7);
        @(posedge mclk);
        xmit_rst_in <= 1'b0;
        recv_rst_in <= 1'b1;
        #2 check("recv subs", recv_rst_out, 6'h3F);
        @(posedge mclk);
        recv_rst_in <= 1'b0;
        $display("test resets done");
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk);
            code_req <= codes[i];
            #2 check("loop code", loop_out, lexp[i]);
        end
        @(posedge mclk);
        code_req <= 3'h0;
        testmode <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(8'h60, ovr[i]);
            #2 check("loop ovr", loop_out, oexp[i]);
        end
        wr(8'h60, 32'h00);
        wr(8'h6C, 32'h0F);
        #2 check("coding ovr", xmit_rst_out.coding, 1'b1);
        wr(8'h6C, 32'h18C);
        #2 check("path ovr", xmit_rst_out.path, 1'b1);
        wr(8'h6C, 32'h0C);
        wait_both(1'b1);
        $display("test overrides done");
        wr(8'h40, 32'h00);
        wr(8'h64, 32'h00);
        wr(8'h68, 32'h1234);
        rdc(8'h64, 32'h00);
        wr(8'h40, 32'h08);
        wr(8'h68, 32'h1234);
        rdc(8'h64, 32'h02);
        rdc(8'h68, 32'h0000);
        rdc(8'h64, 32'h00);
        wr(8'h40, 32'h18);
        wr(8'h64, 32'h11);
        for (int i = 0; i < 5; i++) wr(8'h68, 32'hA000 + i);
        repeat (2) @(posedge mclk);
        check("ovr word", xmit_word_out, 80'hA004A003A002A001A000);
        check("ovr valid", xmit_word_valid_out, 1'b1);
        rdc(8'h64, 32'h11);
        rdc(8'h68, 32'hA000);
        rdc(8'h64, 32'h13);
        testmode <= 1'b0;
        run <= 1'b0;
        repeat (3) @(posedge mclk);
        check("ext word", xmit_word_out, ext(xmit_data_in,
            xmit_disparity_mode_in, xmit_disparity_value_in));
        check("fab valid", xmit_word_valid_out, 1'b1);
        encoder_en_in <= 1'b1;
        repeat (2) @(posedge mclk);
        check("enc word", xmit_word_out,
            ext(xmit_data_in, 8'h00, 8'h00));
        $display("test data path done");
        wrap_up();
    end
endmodule : tb_top
